// ===== core/vuf_ctrl.sv
// Input undervoltage fault response, power-good and turn-on delay with AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
`include "vuf_consts.svh"
module vuf_ctrl (
	input wire logic clk,
	input wire logic reset,
	input wire vuf_pkg::vuf_axi_req_type axi_req,
	output vuf_pkg::vuf_axi_rsp_type axi_rsp,
	input wire logic [15:0] vin_meas,
	input wire logic [15:0] vout_meas,
	input wire logic [15:0] vout_uv_limit,
	input wire logic [15:0] uvlo_strap,
	input wire logic [15:0] output_voltage_strap,
	input wire logic en_pin,
	input wire logic bias_ok,
	input wire logic other_fault,
	input wire logic alert_line_sense,
	output logic alert_line_drive,
	output logic alert_line_oe,
	output logic out_enable,
	output logic power_good,
	output logic irq
);
	import vuf_pkg::*;

	vuf_regs_type s_q;
	vuf_regs_type s_d;
	logic signed [39:0] vin_fix;
	logic signed [39:0] uv_fix;
	logic signed [39:0] warn_fix;
	logic signed [39:0] ton_fix;
	logic signed [49:0] ton_us_w;
	logic [`VUF_CNT_W-1:0] ton_us;
	logic [`VUF_CNT_W-1:0] retry_us;
	logic uv_low;
	logic warn_ok;
	logic enabled;
	logic stop;
	logic tick;
	logic clear_cmd;
	logic uv_ev;
	logic retry_ev;
	logic [`VUF_IRQ_W-1:0] irq_clr;
	logic [14:0] warn_mant;
	logic [15:0] warn_def;
	logic [15:0] pg_def;

	vuf_lin11_to_fix u_vin (
		.word(vin_meas),
		.value(vin_fix)
	);
	vuf_lin11_to_fix u_uv (
		.word(s_q.uv_th),
		.value(uv_fix)
	);
	vuf_lin11_to_fix u_warn (
		.word(s_q.warn_th),
		.value(warn_fix)
	);
	vuf_lin11_to_fix u_ton (
		.word(s_q.ton),
		.value(ton_fix)
	);

	// Turn-on delay in microseconds; negative reads as zero, overflow saturates
	assign ton_us_w = (50'(ton_fix) * 50'(`VUF_US_PER_MS)) >>> `VUF_FRAC_BITS;
	assign ton_us = ton_us_w[49] ? '0 : (|ton_us_w[48:`VUF_CNT_W] ? '1 : ton_us_w[`VUF_CNT_W-1:0]);
	assign retry_us = `VUF_CNT_W'((`VUF_CNT_W'(s_q.uv_act[`VUF_ACT_DELAY]) + 24'h000001) * `VUF_RETRY_STEP_US);
	assign uv_low = vin_fix < uv_fix;
	assign warn_ok = vin_fix > warn_fix;
	assign enabled = en_pin && s_q.op_on && bias_ok;
	assign stop = !enabled || other_fault;
	assign tick = s_q.pre == 7'(`VUF_US_CYCLES - 1);

	// Strap defaults; warning mantissa scaled so its exponent stays as strapped, power-good scales the whole word
	assign warn_mant = (15'(signed'(uvlo_strap[`VUF_L11_MANT])) * `VUF_WARN_NUM) / `VUF_WARN_DEN;
	assign warn_def = {uvlo_strap[`VUF_L11_EXP], warn_mant[10:0]};
	assign pg_def = 16'((20'(output_voltage_strap) * `VUF_PG_NUM) / `VUF_PG_DEN);

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = d[7:0];
		end
		if (strb[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	always_comb begin
		s_d = s_q;
		clear_cmd = 1'b0;
		uv_ev = 1'b0;
		retry_ev = 1'b0;
		irq_clr = '0;
		s_d.pre = tick ? 7'h00 : s_q.pre + 7'h01;

		// Write channels, taken in either order
		if (axi_req.awvalid && axi_rsp.awready) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && axi_rsp.wready) begin
			s_d.w_got = 1'b1;
			s_d.wdata = axi_req.wdata;
			s_d.wstrb = axi_req.wstrb;
		end
		if (s_q.bvalid && axi_req.bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.aw_got && s_q.w_got) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = `VUF_RESP_OKAY;
			unique case (s_q.awaddr)
				`VUF_BYTE_ADDR(`VUF_IDX_UV_WARN): s_d.warn_th = merge16(s_q.warn_th, s_q.wdata, s_q.wstrb);
				`VUF_BYTE_ADDR(`VUF_IDX_UV_FAULT): s_d.uv_th = merge16(s_q.uv_th, s_q.wdata, s_q.wstrb);
				`VUF_BYTE_ADDR(`VUF_IDX_PG_TH): s_d.pg_th = merge16(s_q.pg_th, s_q.wdata, s_q.wstrb);
				`VUF_BYTE_ADDR(`VUF_IDX_TON): s_d.ton = merge16(s_q.ton, s_q.wdata, s_q.wstrb);
				`VUF_BYTE_ADDR(`VUF_IDX_UV_ACT): begin
					if (s_q.wstrb[0]) begin
						s_d.uv_act = s_q.wdata[7:0];
					end
				end
				`VUF_BYTE_ADDR(`VUF_IDX_CLEAR): clear_cmd = s_q.wstrb[0] && s_q.wdata[0];
				`VUF_BYTE_ADDR(`VUF_IDX_CTRL): begin
					if (s_q.wstrb[0]) begin
						s_d.op_on = s_q.wdata[0];
					end
				end
				`VUF_BYTE_ADDR(`VUF_IDX_IRQ_EN): begin
					if (s_q.wstrb[0]) begin
						s_d.irq_en = s_q.wdata[`VUF_IRQ_W-1:0];
					end
				end
				`VUF_BYTE_ADDR(`VUF_IDX_IRQ_CLR): begin
					if (s_q.wstrb[0]) begin
						irq_clr = s_q.wdata[`VUF_IRQ_W-1:0];
					end
				end
				default: s_d.bresp = `VUF_RESP_SLVERR;
			endcase
		end

		// Read channel, one read outstanding
		if (s_q.rvalid && axi_req.rready) begin
			s_d.rvalid = 1'b0;
		end
		if (axi_req.arvalid && axi_rsp.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = `VUF_RESP_OKAY;
			unique case (axi_req.araddr)
				`VUF_BYTE_ADDR(`VUF_IDX_UV_WARN): s_d.rdata = {16'h0000, s_q.warn_th};
				`VUF_BYTE_ADDR(`VUF_IDX_UV_FAULT): s_d.rdata = {16'h0000, s_q.uv_th};
				`VUF_BYTE_ADDR(`VUF_IDX_UV_ACT): s_d.rdata = {24'h000000, s_q.uv_act};
				`VUF_BYTE_ADDR(`VUF_IDX_PG_TH): s_d.rdata = {16'h0000, s_q.pg_th};
				`VUF_BYTE_ADDR(`VUF_IDX_TON): s_d.rdata = {16'h0000, s_q.ton};
				`VUF_BYTE_ADDR(`VUF_IDX_CTRL): s_d.rdata = {31'h00000000, s_q.op_on};
				`VUF_BYTE_ADDR(`VUF_IDX_STATUS): s_d.rdata = {25'h0000000, s_q.st, alert_line_sense, s_q.pgood,
					out_enable, s_q.fault_flag};
				`VUF_BYTE_ADDR(`VUF_IDX_IRQ_ST): s_d.rdata = {28'h0000000, s_q.irq_st};
				`VUF_BYTE_ADDR(`VUF_IDX_IRQ_EN): s_d.rdata = {28'h0000000, s_q.irq_en};
				`VUF_BYTE_ADDR(`VUF_IDX_CLEAR), `VUF_BYTE_ADDR(`VUF_IDX_IRQ_CLR): s_d.rdata = 32'h00000000;
				default: begin
					s_d.rdata = 32'h00000000;
					s_d.rresp = `VUF_RESP_SLVERR;
				end
			endcase
		end

		// Straps are caught on the first clock after reset release
		if (!s_q.strap_done) begin
			s_d.strap_done = 1'b1;
			s_d.uv_th = uvlo_strap;
			s_d.warn_th = warn_def;
			s_d.pg_th = pg_def;
		end

		// Sequencer
		unique case (s_q.st)
			VUF_S_OFF: begin
				if (!stop) begin
					s_d.st = VUF_S_TON;
					s_d.cnt = ton_us;
				end
			end
			VUF_S_TON, VUF_S_ON: begin
				if (stop) begin
					s_d.st = VUF_S_OFF;
				end else if (uv_low) begin
					s_d.st = VUF_S_FAULT;
					uv_ev = 1'b1;
				end else if (s_q.st == VUF_S_TON) begin
					if (s_q.cnt == '0) begin
						s_d.st = VUF_S_ON;
					end else if (tick) begin
						s_d.cnt = s_q.cnt - 24'h000001;
					end
				end
			end
			VUF_S_FAULT: begin
				if (stop) begin
					s_d.st = VUF_S_OFF;
				end else if (clear_cmd) begin
					s_d.st = VUF_S_OFF;
				end else if (s_q.uv_act[`VUF_ACT_RESP] == `VUF_RESP_HOLD) begin
					if (warn_ok) begin
						s_d.st = VUF_S_TON;
						s_d.cnt = ton_us;
					end
				end else if (s_q.uv_act[`VUF_ACT_RESP] == `VUF_RESP_RETRY &&
					s_q.uv_act[`VUF_ACT_RETRY] == `VUF_RETRY_CONT && warn_ok) begin
					s_d.st = VUF_S_RETRY;
					s_d.cnt = retry_us;
				end
				// Unused response and retry codes, and no-retry, stay off until cleared or shut down
			end
			VUF_S_RETRY: begin
				if (stop) begin
					s_d.st = VUF_S_OFF;
				end else if (s_q.cnt != '0) begin
					if (tick) begin
						s_d.cnt = s_q.cnt - 24'h000001;
					end
				end else if (warn_ok) begin
					s_d.st = VUF_S_TON;
					s_d.cnt = ton_us;
					retry_ev = 1'b1;
				end
			end
			default: s_d.st = VUF_S_OFF;
		endcase

		// Power-good hysteresis between its threshold and the undervoltage limit
		if (s_q.st != VUF_S_ON) begin
			s_d.pgood = 1'b0;
		end else if (vout_meas > s_q.pg_th) begin
			s_d.pgood = 1'b1;
		end else if (vout_meas < vout_uv_limit) begin
			s_d.pgood = 1'b0;
		end

		// Set beats clear so a fault in the clearing cycle survives
		s_d.fault_flag = (s_q.fault_flag && !clear_cmd) || uv_ev;
		s_d.irq_st = (s_q.irq_st & ~irq_clr) |
			{retry_ev, s_q.pgood && !s_d.pgood, !s_q.pgood && s_d.pgood, uv_ev};
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
			s_q.st <= VUF_S_OFF;
			s_q.uv_act <= `VUF_ACT_RST;
			s_q.ton <= `VUF_TON_RST;
			s_q.op_on <= `VUF_OP_ON_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign axi_rsp.awready = !s_q.aw_got && !s_q.bvalid;
	assign axi_rsp.wready = !s_q.w_got && !s_q.bvalid;
	assign axi_rsp.bvalid = s_q.bvalid;
	assign axi_rsp.bresp = s_q.bresp;
	assign axi_rsp.arready = !s_q.rvalid;
	assign axi_rsp.rvalid = s_q.rvalid;
	assign axi_rsp.rdata = s_q.rdata;
	assign axi_rsp.rresp = s_q.rresp;
	// Open-drain alert only ever pulls low; the enable carries the flag
	assign alert_line_drive = 1'b0;
	assign alert_line_oe = s_q.fault_flag;
	assign out_enable = s_q.st == VUF_S_ON;
	assign power_good = s_q.pgood;
	assign irq = |(s_q.irq_st & s_q.irq_en);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	AST_UV_ALERT: assert property ((s_q.st == VUF_S_ON) && !stop && uv_low |=>
		s_q.fault_flag && alert_line_oe && !out_enable ##1 s_q.fault_flag)
		else $error("undervoltage did not raise the alert");
	AST_FLAG_STICKY: assert property (s_q.fault_flag && !clear_cmd |=> s_q.fault_flag)
		else $error("fault flag dropped without clear command");
	AST_NO_RETRY: assert property ((s_q.st == VUF_S_FAULT) && !stop && !clear_cmd &&
		(s_q.uv_act[`VUF_ACT_RETRY] == `VUF_RETRY_NONE) && (s_q.uv_act[`VUF_ACT_RESP] == `VUF_RESP_RETRY)
		|=> (s_q.st == VUF_S_FAULT) && !out_enable)
		else $error("restart without retry enabled");
	AST_HOLD_RESUME: assert property ((s_q.st == VUF_S_FAULT) && !stop && !clear_cmd && warn_ok &&
		(s_q.uv_act[`VUF_ACT_RESP] == `VUF_RESP_HOLD) |=> (s_q.st == VUF_S_TON) && (s_q.cnt == $past(ton_us)))
		else $error("hold response did not resume above warning");
	AST_RETRY_GATED: assert property ((s_q.st == VUF_S_RETRY) && !warn_ok |=> s_q.st != VUF_S_TON)
		else $error("retry started below warning threshold");
	AST_RETRY_STOP: assert property ((s_q.st == VUF_S_RETRY || s_q.st == VUF_S_FAULT) && stop
		|=> s_q.st == VUF_S_OFF)
		else $error("retry continued after shutdown request");
	AST_RETRY_SPACING: assert property ((s_q.st == VUF_S_FAULT) ##1 (s_q.st == VUF_S_RETRY)
		|-> s_q.cnt == 24'((24'(s_q.uv_act[`VUF_ACT_DELAY]) + 24'h000001) * `VUF_RETRY_STEP_US))
		else $error("retry delay loaded wrong");
	AST_TON_LOAD: assert property ((s_q.st == VUF_S_OFF) ##1 (s_q.st == VUF_S_TON) |->
		(s_q.cnt == $past(ton_us)) && !out_enable)
		else $error("turn-on delay not loaded");
	AST_PG_RISE: assert property (out_enable && !stop && !uv_low && (vout_meas > s_q.pg_th) |=> power_good)
		else $error("power-good did not assert");
	AST_STRAP_LOAD: assert property (!s_q.strap_done |=> (s_q.uv_th == $past(uvlo_strap)) &&
		(s_q.pg_th == $past(pg_def)))
		else $error("strap defaults not loaded");
	AST_TON_WAIT: assert property ((s_q.st == VUF_S_TON) && (s_q.cnt != '0) |=> !out_enable)
		else $error("output rose before turn-on delay ran out");
	AST_STOP_OFF: assert property ((s_q.st == VUF_S_TON || s_q.st == VUF_S_ON) && stop |=> !out_enable)
		else $error("output stayed on after shutdown request");
	AST_HOLD_WAIT: assert property ((s_q.st == VUF_S_FAULT) && !stop && !clear_cmd && !warn_ok
		|=> s_q.st == VUF_S_FAULT)
		else $error("left fault state below warning threshold");
	AST_PG_ONLY_ON: assert property ((s_q.st != VUF_S_ON) |=> !power_good)
		else $error("power-good high while output not on");
endmodule // vuf_ctrl
`default_nettype wire

// ===== inc/vuf_consts.svh
// Constants for the input undervoltage fault, power-good and turn-on delay control block
`ifndef VUF_CONSTS_SVH
`define VUF_CONSTS_SVH

`define VUF_ADDR_W 12
`define VUF_IDX_UV_WARN 12'h058
`define VUF_IDX_UV_FAULT 12'h059
`define VUF_IDX_UV_ACT 12'h05A
`define VUF_IDX_PG_TH 12'h05E
`define VUF_IDX_TON 12'h060
`define VUF_IDX_CLEAR 12'h0E0
`define VUF_IDX_CTRL 12'h0E1
`define VUF_IDX_STATUS 12'h0E2
`define VUF_IDX_IRQ_ST 12'h0F0
`define VUF_IDX_IRQ_EN 12'h0F1
`define VUF_IDX_IRQ_CLR 12'h0F2
`define VUF_BYTE_ADDR(i) (12'((i) * 12'h004))

`define VUF_RESP_OKAY 2'h0
`define VUF_RESP_SLVERR 2'h2

`define VUF_L11_EXP 15:11
`define VUF_L11_MANT 10:0
`define VUF_FRAC_BITS 8

`define VUF_ACT_RESP 7:6
`define VUF_ACT_RETRY 5:3
`define VUF_ACT_DELAY 2:0
`define VUF_RESP_RETRY 2'h2
`define VUF_RESP_HOLD 2'h3
`define VUF_RETRY_NONE 3'h0
`define VUF_RETRY_CONT 3'h7

`define VUF_ACT_RST 8'hBF
`define VUF_TON_RST 16'hCA80
`define VUF_OP_ON_RST 1'b1
`define VUF_WARN_NUM 15'sh000B
`define VUF_WARN_DEN 15'sh000A
`define VUF_PG_NUM 20'h00009
`define VUF_PG_DEN 20'h0000A

`define VUF_CLK_PERIOD_NS 8
`define VUF_US_NS 1000
`define VUF_US_CYCLES ((`VUF_US_NS + `VUF_CLK_PERIOD_NS - 1) / `VUF_CLK_PERIOD_NS)
`define VUF_US_PER_MS 1000
`define VUF_RETRY_STEP_MS 35
`define VUF_RETRY_STEP_US (`VUF_RETRY_STEP_MS * `VUF_US_PER_MS)
`define VUF_CNT_W 24
`define VUF_IRQ_W 4

`endif

// ===== inc/vuf_pkg.sv
// Types for the input undervoltage fault, power-good and turn-on delay control block
`include "vuf_consts.svh"
package vuf_pkg;
	typedef enum logic [2:0] {
		VUF_S_OFF = 3'h0,
		VUF_S_TON = 3'h1,
		VUF_S_ON = 3'h2,
		VUF_S_FAULT = 3'h3,
		VUF_S_RETRY = 3'h4
	} vuf_state_type;

	typedef struct packed {
		logic [`VUF_ADDR_W-1:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [`VUF_ADDR_W-1:0] araddr;
		logic arvalid;
		logic rready;
	} vuf_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} vuf_axi_rsp_type;

	typedef struct packed {
		vuf_state_type st;
		logic [15:0] uv_th;
		logic [7:0] uv_act;
		logic [15:0] warn_th;
		logic [15:0] pg_th;
		logic [15:0] ton;
		logic op_on;
		logic fault_flag;
		logic pgood;
		logic [`VUF_IRQ_W-1:0] irq_st;
		logic [`VUF_IRQ_W-1:0] irq_en;
		logic strap_done;
		logic [6:0] pre;
		logic [`VUF_CNT_W-1:0] cnt;
		logic aw_got;
		logic [`VUF_ADDR_W-1:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} vuf_regs_type;
endpackage

// ===== core/vuf_lin11_to_fix.sv
// Linear-11 word to signed fixed point with eight fraction bits
`timescale 1ns/1ns
`default_nettype none
`include "vuf_consts.svh"
module vuf_lin11_to_fix (
	input wire logic [15:0] word,
	output logic signed [39:0] value
);
	logic signed [5:0] sh;
	logic signed [39:0] mant;

	always_comb begin
		sh = 6'(signed'(word[`VUF_L11_EXP])) + 6'(`VUF_FRAC_BITS);
		mant = 40'(signed'(word[`VUF_L11_MANT]));
		if (!sh[5]) begin
			value = mant <<< sh[4:0];
		end else begin
			value = mant >>> 5'(-sh);
		end
	end
endmodule // vuf_lin11_to_fix
`default_nettype wire

// ===== tb/vuf_host.sv
// Register bus host model for the undervoltage and power-good control block
`timescale 1ns/1ns
`default_nettype none
module vuf_host (
	input wire logic clk,
	output vuf_pkg::vuf_axi_req_type req,
	input wire vuf_pkg::vuf_axi_rsp_type rsp
);
	import vuf_pkg::*;
	initial req = '0;
	// Each channel holds until its own ready, so either order of acceptance works
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= s;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (!aw && rsp.awready === 1'b1) begin
				aw = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (!w && rsp.wready === 1'b1) begin
				w = 1'b1;
				req.wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (rsp.bvalid !== 1'b1);
		req.bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do @(posedge clk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge clk); while (rsp.rvalid !== 1'b1);
		req.rready <= 1'b0;
	endtask
endmodule // vuf_host
`default_nettype wire

// ===== tb/tb_vin_uv_fault_pgood_ton_ctrl.sv
// Self-checking bench for the undervoltage fault, power-good and turn-on delay block
`timescale 1ns/1ns
`default_nettype none
`include "vuf_consts.svh"
module tb_vin_uv_fault_pgood_ton_ctrl;
	import vuf_pkg::*;
	localparam logic [11:0] A_UV = `VUF_BYTE_ADDR(`VUF_IDX_UV_FAULT);
	localparam logic [11:0] A_ACT = `VUF_BYTE_ADDR(`VUF_IDX_UV_ACT);
	localparam logic [11:0] A_PG = `VUF_BYTE_ADDR(`VUF_IDX_PG_TH);
	localparam logic [11:0] A_TON = `VUF_BYTE_ADDR(`VUF_IDX_TON);
	localparam logic [11:0] A_CLR = `VUF_BYTE_ADDR(`VUF_IDX_CLEAR);
	localparam logic [11:0] A_CTL = `VUF_BYTE_ADDR(`VUF_IDX_CTRL);
	localparam logic [11:0] A_ST = `VUF_BYTE_ADDR(`VUF_IDX_STATUS);
	localparam logic [11:0] A_IST = `VUF_BYTE_ADDR(`VUF_IDX_IRQ_ST);
	localparam logic [11:0] A_IEN = `VUF_BYTE_ADDR(`VUF_IDX_IRQ_EN);
	localparam logic [11:0] A_ICL = `VUF_BYTE_ADDR(`VUF_IDX_IRQ_CLR);
	// Whole-volt values with exponent zero, so mantissa equals volts
	localparam logic [15:0] UVLO = 16'h0050;
	localparam logic [15:0] VOUT_STRAP = 16'h0064;
	logic clk = 1'b0;
	logic reset = 1'b1;
	vuf_axi_req_type req;
	vuf_axi_rsp_type rsp;
	logic [15:0] vin_meas = 16'h0064;
	logic [15:0] vout_meas = 16'h0000;
	logic [15:0] vout_uv_limit = 16'h0040;
	logic en_pin = 1'b0;
	logic bias_ok = 1'b1;
	logic other_fault = 1'b0;
	logic alert_line_drive;
	logic alert_line_oe;
	logic out_enable;
	logic power_good;
	logic irq;
	wire logic alert_line_sense;
	wire logic [3:0] pins;
	int err_total = 0;
	int checks_done = 0;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [31:0] seed;
	// Pull-up on the open-drain alert wire
	assign alert_line_sense = alert_line_oe ? alert_line_drive : 1'b1;
	assign pins = {irq, power_good, out_enable, alert_line_oe};
	always #4 clk = ~clk;
	vuf_host host (.clk(clk), .req(req), .rsp(rsp));
	vuf_ctrl uut (.clk(clk), .reset(reset), .axi_req(req), .axi_rsp(rsp), .vin_meas(vin_meas),
		.vout_meas(vout_meas), .vout_uv_limit(vout_uv_limit), .uvlo_strap(UVLO),
		.output_voltage_strap(VOUT_STRAP), .en_pin(en_pin), .bias_ok(bias_ok), .other_fault(other_fault),
		.alert_line_sense(alert_line_sense), .alert_line_drive(alert_line_drive), .alert_line_oe(alert_line_oe),
		.out_enable(out_enable), .power_good(power_good), .irq(irq));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp_word(input logic [33:0] e, input logic [33:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic cmp_bit(input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	// Monitor pairs each answer with the oldest note
	always @(posedge clk) begin
		if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
			if (rq.size() == 0) cmp_word(34'h0, {rsp.rresp, rsp.rdata});
			else cmp_word(rq.pop_front(), {rsp.rresp, rsp.rdata});
		end
		if (rsp.bvalid === 1'b1 && req.bready === 1'b1) begin
			if (bq.size() == 0) cmp_word(34'h0, {32'h0, rsp.bresp});
			else cmp_word({32'h0, bq.pop_front()}, {32'h0, rsp.bresp});
		end
	end
	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		rq.push_back({r, d});
		host.rd(a);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
		bq.push_back(r);
		host.wr(a, d, s);
	endtask
	// Bounded wait, then the level is judged
	task automatic await(input int b, input logic e);
		for (int i = 0; i < 2000 && pins[b] !== e; i++) @(posedge clk);
		#1 cmp_bit(e, pins[b]);
	endtask
	task automatic hold_off(input int b, input logic e);
		repeat (50) @(posedge clk);
		#1 cmp_bit(e, pins[b]);
	endtask
	// Cycles from enable to output on must fall in a window of whole microseconds
	task automatic ton_span(input int lo, input int hi);
		int n;
		n = 0;
		while (pins[1] !== 1'b1 && n < hi) begin
			@(posedge clk);
			n++;
		end
		#1 cmp_bit(1'b1, (n >= lo) && (pins[1] === 1'b1));
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge clk);
		err_total++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rd(A_ACT, 32'h0000_00BF, `VUF_RESP_OKAY);
		rd(A_TON, 32'h0000_CA80, `VUF_RESP_OKAY);
		rd(A_UV, {16'h0, UVLO}, `VUF_RESP_OKAY);
		rd(A_PG, {16'h0, VOUT_STRAP * 16'h0009 / 16'h000A}, `VUF_RESP_OKAY);
		rd(12'h004, 32'h0, `VUF_RESP_SLVERR);
		wr(12'h004, 32'h1, 4'hF, `VUF_RESP_SLVERR);
		done("reset values");
		seed = 32'hA512;
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr(A_UV, seed, 4'hF, `VUF_RESP_OKAY);
			rd(A_UV, {16'h0, seed[15:0]}, `VUF_RESP_OKAY);
		end
		wr(A_UV, {16'h0, UVLO}, 4'hF, `VUF_RESP_OKAY);
		wr(A_PG, 32'h0000_1177, 4'h1, `VUF_RESP_OKAY);
		rd(A_PG, 32'h0000_0077, `VUF_RESP_OKAY);
		wr(A_PG, 32'h0000_005A, 4'h3, `VUF_RESP_OKAY);
		done("register access");
		// Exponent -8, mantissa 3: 3/256 ms, about 11.7 us
		wr(A_TON, 32'h0000_C003, 4'h3, `VUF_RESP_OKAY);
		wr(A_ACT, 32'h0000_0080, 4'h1, `VUF_RESP_OKAY);
		wr(A_IEN, 32'h1, 4'h1, `VUF_RESP_OKAY);
		@(posedge clk) en_pin <= 1'b1;
		ton_span(10 * `VUF_US_CYCLES, 12 * `VUF_US_CYCLES);
		@(posedge clk) vout_meas <= 16'h0064;
		await(2, 1'b1);
		@(posedge clk) vout_meas <= 16'h0030;
		await(2, 1'b0);
		done("turn on and power good");
		@(posedge clk) vin_meas <= 16'h0046;
		await(0, 1'b1);
		await(1, 1'b0);
		await(3, 1'b1);
		@(posedge clk) vin_meas <= 16'h0064;
		hold_off(1, 1'b0);
		rd(A_ST, {25'h0, VUF_S_FAULT, 4'h1}, `VUF_RESP_OKAY);
		wr(A_IEN, 32'h0, 4'h1, `VUF_RESP_OKAY);
		await(3, 1'b0);
		wr(A_IEN, 32'h1, 4'h1, `VUF_RESP_OKAY);
		await(3, 1'b1);
		wr(A_ICL, 32'h1, 4'h1, `VUF_RESP_OKAY);
		await(3, 1'b0);
		rd(A_IST, 32'h0000_0006, `VUF_RESP_OKAY);
		hold_off(0, 1'b1);
		wr(A_CLR, 32'h1, 4'h1, `VUF_RESP_OKAY);
		await(0, 1'b0);
		await(1, 1'b1);
		done("fault with no retry");
		wr(A_ACT, 32'h0000_00C0, 4'h1, `VUF_RESP_OKAY);
		@(posedge clk) vin_meas <= 16'h0046;
		await(1, 1'b0);
		@(posedge clk) vin_meas <= 16'h0052;
		hold_off(1, 1'b0);
		@(posedge clk) vin_meas <= 16'h0064;
		await(1, 1'b1);
		hold_off(0, 1'b1);
		done("fault with hold");
		@(posedge clk) vin_meas <= 16'h0046;
		await(1, 1'b0);
		@(posedge clk) other_fault <= 1'b1;
		@(posedge clk) vin_meas <= 16'h0064;
		hold_off(1, 1'b0);
		rd(A_ST, {25'h0, VUF_S_OFF, 4'h1}, `VUF_RESP_OKAY);
		@(posedge clk) other_fault <= 1'b0;
		await(1, 1'b1);
		wr(A_CTL, 32'h0, 4'h1, `VUF_RESP_OKAY);
		await(1, 1'b0);
		rd(A_CTL, 32'h0, `VUF_RESP_OKAY);
		wr(A_CTL, 32'h1, 4'h1, `VUF_RESP_OKAY);
		@(posedge clk) bias_ok <= 1'b0;
		hold_off(1, 1'b0);
		@(posedge clk) bias_ok <= 1'b1;
		await(1, 1'b1);
		done("shutdown requests");
		close_out();
	end
endmodule // tb_vin_uv_fault_pgood_ton_ctrl
`default_nettype wire
